/* dsr_core_regs.sv */
// Core system registers: multiplier, product, pointers, PC/stack, accumulators
// Overview of operation
// - Fetch only from internal program memory, 30K words from 800h.
// - Data memory is 640 words of 17 bits, bit 16 a tag.
// - Multiplier operand register, loaded by moves, feeds multiply and multiply-accumulate; shifts use the decoded amount.
// - Barrel shift decodes 4-bit shift amount k to one-hot bit k.
// - Lookup pointer loaded only by lookups, then advances each fetch.
// - Program counter advances by one or two words per instruction.
// - Taken interrupt saves next address; interrupt return reloads it.
// - Call pre-increments stack pointer, pushes old holding value, loads PC+2.
// - Return loads PC, then reloads holding register and drops pointer in the same cycle.
// - Interrupt return works as a return, one cycle longer.
// - Product upper takes bits 31..16, is loadable and feeds accumulates.
// - Product lower takes bits 15..0, usable only by accumulator ops.
// - Thirty-two 16-bit accumulators reached only through four index registers.
// - Offset bit selects the partner accumulator sixteen away.
// - Reads fetch selected and partner; writes may pick either one.
// - String ops start at selected word and restore the index afterwards.
// - Index registers are 5 bits, step, load, store and add.
// - Call adds two to the stack pointer, return subtracts two.
`timescale 1ns/1ps
module dsr_core_regs
  import dsr_pkg::*;
#(
  parameter int unsigned DMEM_DEPTH = DMEM_WORDS
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 cmd_valid,
  input  wire dsr_op_t              cmd_op,
  input  wire logic [15:0]          cmd_data,
  input  wire logic [15:0]          cmd_addr,
  input  wire logic                 cmd_tag,
  input  wire logic [1:0]           cmd_ap_sel,
  input  wire dsr_pre_t             cmd_pre,
  input  wire logic                 cmd_offset,
  input  wire logic                 cmd_wr_partner,
  input  wire logic                 cmd_double,
  output logic                      cmd_ready,
  output logic [15:0]               pc,
  output logic [15:0]               return_holding_register,
  output logic [15:0]               stack_pointer,
  output logic [15:0]               multiplier_operand,
  output logic [3:0]                shift_amount,
  output logic [15:0]               lookup_pointer,
  output logic [15:0]               lookup_addr,
  output logic                      lookup_strobe,
  output logic [15:0]               product_upper,
  output logic [3:0][4:0]           accumulator_index,
  output logic [15:0]               acc_sel_value,
  output logic [15:0]               acc_partner_value,
  output logic [16:0]               dmem_rd_data,
  output logic [15:0]               fetch_addr,
  output logic                      fetch_ok
);
  if (DMEM_DEPTH < 2 || DMEM_DEPTH > 65536) begin : g_chk
    $error("dsr_core_regs: DMEM_DEPTH out of range");
  end

  localparam int unsigned AW = $clog2(DMEM_DEPTH);

  typedef struct packed {
    logic            ready;
    dsr_state_t      st;
    logic [15:0]     pc;
    logic [15:0]     ret_hold;
    logic [15:0]     sp;
    logic [15:0]     mul_op;
    logic [3:0]      shamt;
    logic [15:0]     lk_ptr;
    logic [15:0]     lk_addr;
    logic            lk_stb;
    logic [15:0]     prod_hi;
    logic [15:0]     prod_lo;
    logic [3:0][4:0] ap;
    logic [15:0]     acc_sel;
    logic [15:0]     acc_par;
    logic [16:0]     dm_rd;
    logic [15:0]     fetch_addr;
    logic            fetch_ok;
    logic            str_active;
    logic [1:0]      str_ap;
    logic [4:0]      str_save;
  } dsr_state_reg_t;

  dsr_state_reg_t r;
  dsr_state_reg_t next_r;

  logic [1:0]  rst_sync;
  logic        rst_n_int;
  logic [16:0] dmem [DMEM_DEPTH];
  logic        dm_we;
  logic [15:0] dm_addr;
  logic [16:0] dm_wdata;
  logic [15:0] dm_raddr;
  logic [16:0] dm_rdata;
  logic [4:0]  eff_idx;
  logic [15:0] sel_val;
  logic [31:0] prod;
  logic        go;

  dsr_acc_if ai ();

  dsr_acc_file #(
    .N (ACC_NUM)
  ) u_acc (
    .clk (clk),
    .ai  (ai)
  );

  function automatic logic dm_hit(input logic [15:0] a);
    return 32'(a) < DMEM_DEPTH;
  endfunction

  // Reset release through two stages
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync[1];

  // Data memory: 17-bit words, bit 16 carries the tag
  always_ff @(posedge clk) begin
    if (dm_we && dm_hit(dm_addr)) begin
      dmem[dm_addr[AW-1:0]] <= dm_wdata;
    end
  end

  assign dm_raddr = (r.st == ST_IDLE) ? cmd_addr : r.sp;
  assign dm_rdata = dm_hit(dm_raddr) ? dmem[dm_raddr[AW-1:0]] : 17'h0_0000;

  assign go = cmd_valid && r.ready;

  always_comb begin
    next_r        = r;
    next_r.lk_stb = 1'b0;
    dm_we         = 1'b0;
    dm_addr       = r.sp;
    dm_wdata      = 17'h0_0000;
    prod          = 32'h0000_0000;
    eff_idx       = dsr_idx_step(r.ap[cmd_ap_sel], cmd_pre);
    ai.idx        = eff_idx;
    ai.wr_en      = 1'b0;
    ai.wr_partner = cmd_wr_partner;
    ai.wr_data    = 16'h0000;
    sel_val       = cmd_offset ? ai.rd_partner : ai.rd_main;

    unique case (r.st)
      ST_IDLE: begin
        if (go) begin
          if (cmd_pre != PRE_NONE) begin
            next_r.ap[cmd_ap_sel] = eff_idx;
          end
          unique case (cmd_op)
            OP_NOP: begin
            end
            OP_STEP: begin
              next_r.pc = r.pc + (cmd_double ? PC_STEP2 : PC_STEP1);
            end
            OP_LD_MULOP: next_r.mul_op = cmd_data;
            OP_LD_SHAMT: next_r.shamt = cmd_data[3:0];
            OP_LD_PHI: next_r.prod_hi = cmd_data;
            OP_MUL: begin
              prod = {16'h0000, r.mul_op} * {16'h0000, cmd_data};
              next_r.prod_hi = prod[31:16];
              next_r.prod_lo = prod[15:0];
            end
            OP_MAC: begin
              prod = {16'h0000, r.mul_op} * {16'h0000, cmd_data};
              next_r.prod_hi = prod[31:16];
              next_r.prod_lo = prod[15:0];
              ai.wr_en       = 1'b1;
              ai.wr_data     = sel_val + r.prod_lo;
            end
            OP_SHIFT: begin
              prod = {16'h0000, dsr_shift_decode(r.shamt)} *
                     {16'h0000, cmd_data};
              next_r.prod_hi = prod[31:16];
              next_r.prod_lo = prod[15:0];
            end
            OP_LOOKUP: begin
              next_r.lk_addr = cmd_data;
              next_r.lk_stb  = 1'b1;
              next_r.lk_ptr  = cmd_data + PC_STEP1;
            end
            OP_COEF: begin
              next_r.lk_addr = r.lk_ptr;
              next_r.lk_stb  = 1'b1;
              next_r.lk_ptr  = r.lk_ptr + PC_STEP1;
            end
            OP_CALL: begin
              next_r.sp       = r.sp + SP_STEP;
              dm_we           = 1'b1;
              dm_addr         = next_r.sp;
              dm_wdata        = {1'b0, r.ret_hold};
              next_r.ret_hold = r.pc + LINK_OFS;
              next_r.pc       = cmd_data;
            end
            OP_INT: begin
              next_r.sp       = r.sp + SP_STEP;
              dm_we           = 1'b1;
              dm_addr         = next_r.sp;
              dm_wdata        = {1'b0, r.ret_hold};
              next_r.ret_hold = r.pc;
              next_r.pc       = cmd_data;
            end
            OP_SUB_RTN: begin
              next_r.pc = r.ret_hold;
              next_r.st = ST_RTN_POP;
            end
            OP_INT_RTN: begin
              next_r.pc = r.ret_hold;
              next_r.st = ST_IRTN_POP;
            end
            OP_AP_LD: next_r.ap[cmd_ap_sel] = cmd_data[4:0];
            OP_AP_LDM: next_r.ap[cmd_ap_sel] = dm_rdata[4:0];
            OP_AP_ST: begin
              dm_we    = 1'b1;
              dm_addr  = cmd_addr;
              dm_wdata = {12'h000, eff_idx};
            end
            OP_AP_ADD: begin
              next_r.ap[cmd_ap_sel] = eff_idx + cmd_data[4:0];
            end
            OP_ACC_WR: begin
              ai.wr_en   = 1'b1;
              ai.wr_data = cmd_data;
            end
            OP_ACC_ADDPL: begin
              ai.wr_en   = 1'b1;
              ai.wr_data = sel_val + r.prod_lo;
            end
            OP_ACC_SUBPL: begin
              ai.wr_en   = 1'b1;
              ai.wr_data = sel_val - r.prod_lo;
            end
            OP_ACC_MOVPL: begin
              ai.wr_en   = 1'b1;
              ai.wr_data = r.prod_lo;
            end
            OP_ACC_ADDPH: begin
              ai.wr_en   = 1'b1;
              ai.wr_data = sel_val + r.prod_hi;
            end
            OP_DM_WR: begin
              dm_we    = 1'b1;
              dm_addr  = cmd_addr;
              dm_wdata = {cmd_tag, cmd_data};
            end
            OP_DM_RD: next_r.dm_rd = dm_rdata;
            OP_STR_BEG: begin
              next_r.str_active = 1'b1;
              next_r.str_ap     = cmd_ap_sel;
              next_r.str_save   = r.ap[cmd_ap_sel];
            end
            OP_STR_NEXT: begin
              if (r.str_active) begin
                next_r.ap[r.str_ap] =
                  dsr_idx_step(r.ap[r.str_ap], PRE_INC);
              end
            end
            OP_STR_END: begin
              if (r.str_active) begin
                next_r.ap[r.str_ap] = r.str_save;
              end
              next_r.str_active = 1'b0;
            end
          endcase
        end
      end
      ST_RTN_POP: begin
        next_r.ret_hold = dm_rdata[15:0];
        next_r.sp       = r.sp - SP_STEP;
        next_r.st       = ST_IDLE;
      end
      ST_IRTN_POP: begin
        next_r.ret_hold = dm_rdata[15:0];
        next_r.sp       = r.sp - SP_STEP;
        next_r.st       = ST_IRTN_WAIT;
      end
      ST_IRTN_WAIT: begin
        next_r.st = ST_IDLE;
      end
    endcase

    next_r.ready      = (next_r.st == ST_IDLE);
    next_r.acc_sel    = sel_val;
    next_r.acc_par    = cmd_offset ? ai.rd_main : ai.rd_partner;
    next_r.fetch_addr = next_r.pc;
    next_r.fetch_ok   = dsr_in_pmem(next_r.pc);
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      r            <= '0;
      r.ready      <= 1'b1;
      r.st         <= ST_IDLE;
      r.pc         <= RST_WORD;
      r.ret_hold   <= RST_WORD;
      r.sp         <= RST_WORD;
      r.mul_op     <= RST_WORD;
      r.shamt      <= RST_SV;
      r.lk_ptr     <= RST_WORD;
      r.prod_hi    <= RST_WORD;
      r.prod_lo    <= RST_WORD;
      r.ap         <= {4{RST_IDX}};
      r.fetch_addr <= RST_WORD;
    end else begin
      r <= next_r;
    end
  end

  assign cmd_ready               = r.ready;
  assign pc                      = r.pc;
  assign return_holding_register = r.ret_hold;
  assign stack_pointer           = r.sp;
  assign multiplier_operand      = r.mul_op;
  assign shift_amount            = r.shamt;
  assign lookup_pointer          = r.lk_ptr;
  assign lookup_addr             = r.lk_addr;
  assign lookup_strobe           = r.lk_stb;
  assign product_upper           = r.prod_hi;
  assign accumulator_index       = r.ap;
  assign acc_sel_value           = r.acc_sel;
  assign acc_partner_value       = r.acc_par;
  assign dmem_rd_data            = r.dm_rd;
  assign fetch_addr              = r.fetch_addr;
  assign fetch_ok                = r.fetch_ok;
endmodule

/* dsr_pkg.sv */
// Shared constants, types and helpers for the core system register block
package dsr_pkg;
  localparam int unsigned DW         = 16;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned SHAMT_W    = 4;
  localparam int unsigned ACC_NUM    = 32;
  localparam int unsigned DMEM_WORDS = 640;
  localparam int unsigned PMEM_WORDS = 30720;
  localparam logic [15:0] PMEM_BASE  = 16'h0800;
  localparam logic [16:0] PMEM_END   = 17'(PMEM_BASE) + 17'(PMEM_WORDS);
  localparam logic [4:0]  PARTNER_OFS = 5'h10;
  localparam logic [15:0] SP_STEP    = 16'h0002;
  localparam logic [15:0] LINK_OFS   = 16'h0002;
  localparam logic [15:0] PC_STEP1   = 16'h0001;
  localparam logic [15:0] PC_STEP2   = 16'h0002;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [4:0]  RST_IDX    = 5'h00;
  localparam logic [3:0]  RST_SV     = 4'h0;
  localparam logic [15:0] SHIFT_ONE  = 16'h0001;

  typedef enum logic [4:0] {
    OP_NOP, OP_STEP, OP_LD_MULOP, OP_LD_SHAMT, OP_LD_PHI, OP_MUL, OP_MAC,
    OP_SHIFT, OP_LOOKUP, OP_COEF, OP_CALL, OP_SUB_RTN, OP_INT_RTN, OP_INT,
    OP_AP_LD, OP_AP_LDM, OP_AP_ST, OP_AP_ADD, OP_ACC_WR, OP_ACC_ADDPL,
    OP_ACC_SUBPL, OP_ACC_MOVPL, OP_ACC_ADDPH, OP_DM_WR, OP_DM_RD,
    OP_STR_BEG, OP_STR_NEXT, OP_STR_END
  } dsr_op_t;

  typedef enum logic [1:0] {PRE_NONE, PRE_INC, PRE_DEC} dsr_pre_t;

  typedef enum logic [1:0] {
    ST_IDLE, ST_RTN_POP, ST_IRTN_POP, ST_IRTN_WAIT
  } dsr_state_t;

  // One-hot multiplier operand from a shift amount
  function automatic logic [15:0] dsr_shift_decode(input logic [3:0] k);
    return SHIFT_ONE << k;
  endfunction

  // Index step, wrapping inside the 5-bit field
  function automatic logic [4:0] dsr_idx_step(input logic [4:0] idx,
                                               input dsr_pre_t   pre);
    unique case (pre)
      PRE_INC: return idx + 5'h01;
      PRE_DEC: return idx - 5'h01;
      default: return idx;
    endcase
  endfunction

  // Partner sits 16 away, inside 0..31
  function automatic logic [4:0] dsr_partner(input logic [4:0] idx);
    return idx ^ PARTNER_OFS;
  endfunction

  function automatic logic dsr_in_pmem(input logic [15:0] a);
    return (a >= PMEM_BASE) && ({1'b0, a} < PMEM_END);
  endfunction
endpackage

/* dsr_acc_if.sv */
// Accumulator file port bundle between core logic and the array
`timescale 1ns/1ps
interface dsr_acc_if;
  import dsr_pkg::*;
  logic [IDX_W-1:0] idx;
  logic [DW-1:0]    rd_main;
  logic [DW-1:0]    rd_partner;
  logic             wr_en;
  logic             wr_partner;
  logic [DW-1:0]    wr_data;
  modport core (output idx, output wr_en, output wr_partner,
                output wr_data, input rd_main, input rd_partner);
  modport file (input idx, input wr_en, input wr_partner,
                input wr_data, output rd_main, output rd_partner);
endinterface

/* dsr_acc_file.sv */
// Accumulator array with paired read and selectable write target
`timescale 1ns/1ps
module dsr_acc_file
  import dsr_pkg::*;
#(
  parameter int unsigned N = ACC_NUM
) (
  input wire logic clk,
  dsr_acc_if.file  ai
);
  if (N != (1 << IDX_W)) begin : g_chk
    $error("dsr_acc_file: N must match the index width");
  end

  // Contents survive reset, as working RAM does
  logic [DW-1:0] acc [N];

  assign ai.rd_main    = acc[ai.idx];
  assign ai.rd_partner = acc[dsr_partner(ai.idx)];

  always_ff @(posedge clk) begin
    if (ai.wr_en) begin
      acc[ai.wr_partner ? dsr_partner(ai.idx) : ai.idx] <= ai.wr_data;
    end
  end
endmodule

/* dsr_core_regs_monitor.sv */
// Port-level assertions for the core system register block
`timescale 1ns/1ps
module dsr_core_regs_monitor
  import dsr_pkg::*;
(
  input wire logic            clk,
  input wire logic            rstn,
  input wire logic            cmd_valid,
  input wire dsr_op_t         cmd_op,
  input wire logic [15:0]     cmd_data,
  input wire logic [1:0]      cmd_ap_sel,
  input wire dsr_pre_t        cmd_pre,
  input wire logic            cmd_double,
  input wire logic            cmd_ready,
  input wire logic [15:0]     pc,
  input wire logic [15:0]     return_holding_register,
  input wire logic [15:0]     stack_pointer,
  input wire logic [15:0]     multiplier_operand,
  input wire logic [15:0]     lookup_pointer,
  input wire logic [15:0]     lookup_addr,
  input wire logic            lookup_strobe,
  input wire logic [3:0][4:0] accumulator_index,
  input wire logic [15:0]     fetch_addr,
  input wire logic            fetch_ok
);
  wire take = cmd_valid && cmd_ready;
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rstn);

  mulop_load_a: assert property (
    take && cmd_op == OP_LD_MULOP |=> multiplier_operand == $past(cmd_data))
    else $error("multiplier operand not loaded");
  lookup_load_a: assert property (
    take && cmd_op == OP_LOOKUP |=> lookup_strobe
      && lookup_addr == $past(cmd_data)
      && lookup_pointer == $past(cmd_data) + 16'h0001)
    else $error("lookup pointer load wrong");
  pointer_hold_a: assert property (
    !(take && cmd_op inside {OP_LOOKUP, OP_COEF}) |=> $stable(lookup_pointer))
    else $error("lookup pointer changed without lookup");
  pc_step_a: assert property (
    take && cmd_op == OP_STEP |=>
      pc == $past(pc) + ($past(cmd_double) ? 16'h0002 : 16'h0001))
    else $error("program counter step wrong");
  call_push_a: assert property (
    take && cmd_op == OP_CALL |=>
      stack_pointer == $past(stack_pointer) + 16'h0002
      && return_holding_register == $past(pc) + 16'h0002
      && pc == $past(cmd_data))
    else $error("call did not push correctly");
  int_save_a: assert property (
    take && cmd_op == OP_INT |=> return_holding_register == $past(pc)
      && pc == $past(cmd_data))
    else $error("interrupt entry did not save next address");
  ret_order_a: assert property (
    take && cmd_op == OP_SUB_RTN |=>
      pc == $past(return_holding_register) && !cmd_ready
      ##1 cmd_ready && stack_pointer == $past(stack_pointer, 2) - 16'h0002)
    else $error("return sequence wrong");
  interrupt_return_op_len_a: assert property (
    take && cmd_op == OP_INT_RTN |=> !cmd_ready [*2] ##1 cmd_ready)
    else $error("interrupt return length wrong");
  idx_wrap_a: assert property (
    take && cmd_op == OP_NOP && cmd_pre == PRE_INC |=>
      accumulator_index[$past(cmd_ap_sel)]
        == $past(accumulator_index[cmd_ap_sel]) + 5'h01)
    else $error("index pre-increment wrong");
  fetch_range_a: assert property (
    fetch_ok == (fetch_addr >= PMEM_BASE && {1'b0, fetch_addr} < PMEM_END))
    else $error("fetch window flag wrong");

  cover property (take && cmd_op == OP_CALL);
  cover property (take && cmd_op == OP_SUB_RTN);
  cover property (take && cmd_op == OP_INT_RTN);
endmodule

bind dsr_core_regs dsr_core_regs_monitor i_dsr_core_regs_monitor (
  .clk, .rstn, .cmd_valid, .cmd_op, .cmd_data, .cmd_ap_sel, .cmd_pre,
  .cmd_double, .cmd_ready, .pc, .return_holding_register, .stack_pointer,
  .multiplier_operand, .lookup_pointer, .lookup_addr, .lookup_strobe,
  .accumulator_index, .fetch_addr, .fetch_ok);

/* dsr_core_regs_tb.sv */
// Self-checking bench for the core system register block
`timescale 1ns/1ps
module dsr_core_regs_tb
  import dsr_pkg::*;
;
  typedef struct {int s; logic [16:0] v;} dsr_note_t;
  logic clk, rstn, cmd_valid, cmd_tag, cmd_offset, cmd_wr_partner, cmd_double;
  logic cmd_ready, lookup_strobe, fetch_ok, of, wp;
  logic [15:0] cmd_data, cmd_addr, pc, return_holding_register, stack_pointer;
  logic [15:0] multiplier_operand, lookup_pointer, lookup_addr, product_upper;
  logic [15:0] acc_sel_value, acc_partner_value, fetch_addr;
  logic [15:0] mop, phi, plo, d, a, r;
  logic [15:0] ac[2];
  logic [31:0] p;
  logic [16:0] dmem_rd_data;
  logic [4:0]  x;
  logic [3:0][4:0] accumulator_index;
  logic [3:0]  shift_amount;
  logic [1:0]  cmd_ap_sel;
  dsr_op_t     cmd_op, o;
  dsr_pre_t    cmd_pre;
  dsr_note_t   q[$];
  int          n_mismatch, checks_done, k;
  dsr_op_t ops[5] = '{OP_ACC_ADDPL, OP_ACC_SUBPL, OP_ACC_MOVPL,
                      OP_ACC_ADDPH, OP_MAC};

  dsr_core_regs i_dsr_core_regs (
    .clk, .rstn, .cmd_valid, .cmd_op, .cmd_data, .cmd_addr, .cmd_tag,
    .cmd_ap_sel, .cmd_pre, .cmd_offset, .cmd_wr_partner, .cmd_double,
    .cmd_ready, .pc, .return_holding_register, .stack_pointer,
    .multiplier_operand, .shift_amount, .lookup_pointer, .lookup_addr,
    .lookup_strobe, .product_upper, .accumulator_index, .acc_sel_value,
    .acc_partner_value, .dmem_rd_data, .fetch_addr, .fetch_ok);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [16:0] obs(int s);
    case (s)
      0: return 17'(pc);
      1: return 17'(return_holding_register);
      2: return 17'(stack_pointer);
      3: return 17'(multiplier_operand);
      4: return 17'(shift_amount);
      5: return 17'(lookup_pointer);
      6: return 17'(lookup_addr);
      7: return 17'(product_upper);
      8: return 17'(acc_sel_value);
      9: return 17'(acc_partner_value);
      10: return dmem_rd_data;
      11: return 17'(lookup_strobe);
      12: return 17'(cmd_ready);
      13: return 17'(fetch_ok);
      19: return 17'(fetch_addr);
      default: return 17'(accumulator_index[s[1:0]]);
    endcase
  endfunction

  task automatic note(int s, logic [16:0] v, int s2 = -1,
                      logic [16:0] v2 = 17'h0_0000);
    q.push_back('{s, v});
    if (s2 >= 0)
      q.push_back('{s2, v2});
  endtask

  task automatic cmd(dsr_op_t op, logic [15:0] dd, logic [15:0] ad = 0,
                     logic [1:0] ap = 0, dsr_pre_t pr = PRE_NONE,
                     logic f = 0, logic w = 0, logic tg = 0, logic db = 0);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = dd;
    cmd_addr = ad;
    cmd_ap_sel = ap;
    cmd_pre = pr;
    cmd_offset = f;
    cmd_wr_partner = w;
    cmd_tag = tg;
    cmd_double = db;
  endtask

  task automatic idle();
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_pre = PRE_NONE;
  endtask

  // Pair read through index register 0, which points at 25 (partner 9)
  task automatic rd(logic f);
    cmd(OP_NOP, 0, 0, 0, PRE_NONE, f);
    note(8, 17'(ac[f]), 9, 17'(ac[!f]));
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    dsr_note_t n;
    #1;
    while (q.size() > 0) begin
      n = q.pop_front();
      checks_done++;
      if (obs(n.s) !== n.v) begin
        n_mismatch++;
        $display("BAD %0t: output %0d is %h, expected %h",
                 $time, n.s, obs(n.s), n.v);
      end
    end
  end

  initial begin
    #100_000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    {cmd_valid, cmd_tag, cmd_offset, cmd_wr_partner, cmd_double} = '0;
    {cmd_data, cmd_addr, cmd_ap_sel} = '0;
    cmd_op = OP_NOP;
    cmd_pre = PRE_NONE;
    void'($urandom(32'h3abb_d8e0));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    note(0, 0, 2, 0);
    note(13, 0, 12, 1);
    mop = $urandom;
    cmd(OP_LD_MULOP, mop); note(3, 17'(mop));
    cmd(OP_AP_LD, 16'h0019); note(16, 25);
    cmd(OP_ACC_MOVPL, 0, 0, 0, PRE_NONE, 0, 1);
    ac[1] = 16'h0000;
    for (k = 0; k < 16; k++) begin
      d = $urandom;
      cmd(OP_LD_SHAMT, 16'(k)); note(4, 17'(k));
      cmd(OP_SHIFT, d);
      p = 32'(d) << k;
      {phi, plo} = p;
      note(7, 17'(phi));
      cmd(OP_ACC_MOVPL, 0);
      ac[0] = plo;
      rd(0);
    end
    d = $urandom;
    cmd(OP_MUL, d);
    {phi, plo} = 32'(mop) * 32'(d);
    note(7, 17'(phi));
    for (k = 0; k < 15; k++) begin
      o = ops[k % 5];
      of = $urandom;
      wp = $urandom;
      d = $urandom;
      case (o)
        OP_ACC_SUBPL: r = ac[of] - plo;
        OP_ACC_MOVPL: r = plo;
        OP_ACC_ADDPH: r = ac[of] + phi;
        default: r = ac[of] + plo;
      endcase
      cmd(o, d, 0, 0, PRE_NONE, of, wp);
      ac[wp] = r;
      if (o == OP_MAC)
        {phi, plo} = 32'(mop) * 32'(d);
      note(7, 17'(phi));
      rd(of);
    end
    d = $urandom;
    cmd(OP_LD_PHI, d); note(7, 17'(d));
    cmd(OP_ACC_WR, d, 0, 0, PRE_NONE, 0, 1);
    ac[1] = d;
    rd(0);
    cmd(OP_AP_LD, 16'h001f, 0, 1); note(17, 31);
    cmd(OP_NOP, 0, 0, 1, PRE_INC); note(17, 0);
    cmd(OP_NOP, 0, 0, 1, PRE_DEC); note(17, 31);
    d = $urandom;
    x = 5'(31 + d[4:0]);
    cmd(OP_AP_ADD, d, 0, 1); note(17, 17'(x));
    cmd(OP_AP_ST, 0, 16'h0020, 1);
    cmd(OP_DM_RD, 0, 16'h0020); note(10, 17'(x));
    cmd(OP_AP_LDM, 0, 16'h0020, 2); note(18, 17'(x));
    cmd(OP_STR_BEG, 0, 0, 2);
    cmd(OP_STR_NEXT, 0, 0, 2); note(18, 17'(5'(x + 1)));
    cmd(OP_STR_END, 0, 0, 2); note(18, 17'(x));
    for (k = 0; k < 3; k++) begin
      a = (k == 2) ? 16'h0280 : 16'($urandom_range(639, 40));
      d = $urandom;
      cmd(OP_DM_WR, d, a, 0, PRE_NONE, 0, 0, k[0]);
      cmd(OP_DM_RD, 0, a);
      note(10, (k == 2) ? 17'h0_0000 : {k[0], d});
    end
    a = $urandom;
    cmd(OP_LOOKUP, a); note(11, 1, 6, 17'(a));
    note(5, 17'(a + 16'h0001));
    cmd(OP_COEF, 0); note(6, 17'(a + 16'h0001), 5, 17'(a + 16'h0002));
    idle(); note(11, 0, 5, 17'(a + 16'h0002));
    cmd(OP_CALL, 16'h0900); note(0, 17'h0_0900, 1, 2);
    note(2, 2, 13, 1);
    note(19, 17'h0_0900);
    cmd(OP_STEP, 0, 0, 0, PRE_NONE, 0, 0, 0, 1); note(0, 17'h0_0902);
    cmd(OP_STEP, 0); note(0, 17'h0_0903);
    cmd(OP_CALL, 16'h1000); note(1, 17'h0_0905, 2, 4);
    cmd(OP_STEP, 0);
    cmd(OP_SUB_RTN, 0); note(0, 17'h0_0905, 12, 0);
    idle(); note(1, 2, 2, 2);
    cmd(OP_INT, 16'h2000); note(1, 17'h0_0905, 0, 17'h0_2000);
    cmd(OP_STEP, 0);
    cmd(OP_INT_RTN, 0); note(0, 17'h0_0905, 12, 0);
    // Load attempted while busy must be ignored
    cmd(OP_LD_MULOP, ~mop); note(1, 2, 3, 17'(mop));
    note(12, 0, 2, 2);
    idle(); note(12, 1);
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule
